// ### common/sbc_pkg.sv
/*
  Constants, state type and helper functions of the two-wire serial bus
  interface control block.
  Assumes a 32-bit AHB-Lite register bus and one gear clock for all logic.
*/
package sbc_pkg;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_CFG      = 8'h22;
  localparam logic [7:0] IDX_CTRL     = 8'h23;
  localparam logic [7:0] IDX_OWN      = 8'h24;
  localparam logic [7:0] IDX_BUF      = 8'h25;
  localparam logic [7:0] IDX_GATE     = 8'h30;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h31;
  localparam logic [7:0] IDX_IRQ_EN   = 8'h32;
  localparam logic [7:0] IDX_IRQ_CLR  = 8'h33;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CFG_BC_LSB  = 5;
  localparam int CFG_ACK     = 4;
  localparam int CFG_NOMATCH = 3;
  localparam int CTL_MST     = 7;
  localparam int CTL_TRX     = 6;
  localparam int CTL_BB      = 5;
  localparam int CTL_PIN     = 4;
  localparam int CTL_MODE    = 3;
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_AL      = 1;
  localparam int IRQ_MATCH   = 2;
  localparam int IRQ_STOP    = 3;

  // ----------------------------------------------------------------------
  // Reset values, codes and counts
  // ----------------------------------------------------------------------
  localparam logic [7:0] CFG_RST    = 8'h00;
  localparam logic [7:0] OWN_RST    = 8'h00;
  localparam logic [7:0] BUF_RST    = 8'h00;
  localparam logic [3:0] IRQ_RST    = 4'h0;
  localparam logic [1:0] SOFT_RESET_CODE_ARM  = 2'h2;
  localparam logic [1:0] SOFT_RESET_CODE_FIRE = 2'h1;
  localparam logic [6:0] GCALL_ADDR = 7'h00;
  localparam logic [3:0] ADDR_BITS  = 4'h8;
  localparam logic [3:0] ADDR_LAST  = 4'h7;
  localparam logic [8:0] LOW_EXTRA  = 9'h003;
  // SCL rise reaches the counter late: two sync stages, zero cycle, output flop
  localparam logic [8:0] HIGH_LAG   = 9'h004;

  typedef enum logic [2:0] {
    ST_IDLE, ST_START, ST_LOW, ST_HIGH, ST_HOLD, ST_STOP_LOW, ST_STOP_HIGH, ST_SLAVE
  } sbc_state_t;

  function automatic logic sbc_hit(input logic [31:0] addr, input logic [7:0] idx);
    sbc_hit = (addr == {22'h0, idx, 2'h0});
  endfunction

  // SCL high period in gear-clock cycles; low period is three more
  function automatic logic [8:0] sbc_high_cycles(input logic [2:0] sel);
    unique case (sel)
      3'h0: sbc_high_cycles = 9'h009;
      3'h1: sbc_high_cycles = 9'h00b;
      3'h2: sbc_high_cycles = 9'h00f;
      3'h3: sbc_high_cycles = 9'h017;
      3'h4: sbc_high_cycles = 9'h027;
      3'h5: sbc_high_cycles = 9'h047;
      3'h6: sbc_high_cycles = 9'h087;
      3'h7: sbc_high_cycles = 9'h107;
    endcase
  endfunction

  function automatic logic [3:0] sbc_data_bits(input logic [2:0] bc);
    sbc_data_bits = (bc == 3'h0) ? ADDR_BITS : {1'b0, bc};
  endfunction
endpackage

// ### design/sbc_top.sv
/*
  Two-wire serial bus interface control: AHB-Lite registers, master clock
  generation, start/stop generation, slave address match and SCL hold.
  Assumes SCL/SDA are open-drain wires resolved outside, sampled here
  through two flip-flops, and a system power-mode entry pulse on this clock.
*/
// Function
// - Match-disable 0 enables own-address and general-call match in slave mode; 1 disables.
// - Master SCL high m, low n gear cycles from the 3-bit period select.
// - In slave mode the period select sets SCL hold time before release.
// - Soft reset clears config, own address, status except bus busy, and control except mode.
// - Power-mode entry clears config, own address, buffer and control except mode.
// - Start request 1 makes start, 0 makes stop, only with master, transmit, release.
// - Mode select 0 gives port mode pins, 1 gives serial bus mode.
// - With mode select 0 all other control writes are ignored.
// - Soft reset fires only after code 10 then code 01 are written.
// - Reading the control address returns the eight status bits.
// - Gate enable 0 stops the interface clock and discards config, control, own-address and buffer writes.
module sbc_top
  import sbc_pkg::*;
(
  input  wire logic        SYS_CLK_IN,
  input  wire logic        ARST_N_IN,
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output logic      [31:0] HRDATA_OUT,
  output logic             HREADYOUT_OUT,
  output logic             HRESP_OUT,
  input  wire logic        SCL_IN,
  output logic             SCL_OUT,
  output logic             SCL_OE_OUT,
  input  wire logic        SDA_IN,
  output logic             SDA_OUT,
  output logic             SDA_OE_OUT,
  input  wire logic        LOW_POWER_ENTRY_IN,
  output logic             BUS_MODE_OUT,
  output logic             IRQ_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  sbc_state_t  state;
  logic [31:0] ap_addr;
  logic        ap_wr;
  logic [7:0]  wdata;
  logic        clk_gate;
  logic [7:0]  cfg;
  logic [7:0]  own_addr;
  logic [7:0]  shift_buffer;
  logic        master_select, transmit_select, bb, pin, mode_sel, al, aas, ad0, lrb;
  logic        soft_reset_code_armed;
  logic        addr_phase;
  logic [8:0]  cnt;
  logic [3:0]  bit_cnt;
  logic [3:0]  irq_stat, irq_en, irq_clr, irq_ev;
  logic        ev_done, ev_al, ev_match;
  logic        scl_meta, scl_sync, scl_prev, sda_meta, sda_sync, sda_prev;
  logic        scl_rise, scl_fall, start_det, stop_det;
  logic        wsel_cfg, wsel_ctrl, wsel_own, wsel_buf, wsel_gate, wsel_en, wsel_clr;
  logic        soft_rst, init_regs, do_cmd;
  logic [8:0]  m_cycles, n_cycles;
  logic [3:0]  data_bits, total_bits;
  logic        data_slot, next_sda_oe, next_scl_oe, sda_freeze;
  logic [7:0]  rd_byte;

  assign HREADYOUT_OUT = 1'b1;
  assign HRESP_OUT     = 1'b0;
  assign SCL_OUT       = 1'b0;
  assign SDA_OUT       = 1'b0;
  assign BUS_MODE_OUT  = mode_sel;

  // ----------------------------------------------------------------------
  // AHB-Lite slave: zero wait states, read data registered in address phase
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      ap_wr      <= 1'b0;
      ap_addr    <= 32'h0;
      HRDATA_OUT <= 32'h0;
    end else if (HREADY_IN) begin
      ap_wr   <= HSEL_IN & HTRANS_IN[1] & HWRITE_IN;
      ap_addr <= HADDR_IN;
      if (HSEL_IN && HTRANS_IN[1] && !HWRITE_IN) begin
        HRDATA_OUT <= {24'h0, rd_byte};
      end
    end
  end

  always_comb begin
    rd_byte = 8'h00;
    if (sbc_hit(HADDR_IN, IDX_CFG))      rd_byte = cfg;
    if (sbc_hit(HADDR_IN, IDX_CTRL))     rd_byte = {master_select, transmit_select, bb, pin, al, aas, ad0, lrb};
    if (sbc_hit(HADDR_IN, IDX_OWN))      rd_byte = own_addr;
    if (sbc_hit(HADDR_IN, IDX_BUF))      rd_byte = shift_buffer;
    if (sbc_hit(HADDR_IN, IDX_GATE))     rd_byte = {7'h00, clk_gate};
    if (sbc_hit(HADDR_IN, IDX_IRQ_STAT)) rd_byte = {4'h0, irq_stat};
    if (sbc_hit(HADDR_IN, IDX_IRQ_EN))   rd_byte = {4'h0, irq_en};
  end

  // Interface writes die while the gate is off
  assign wdata     = HWDATA_IN[7:0];
  assign wsel_gate = ap_wr & sbc_hit(ap_addr, IDX_GATE);
  assign wsel_cfg  = ap_wr & clk_gate & sbc_hit(ap_addr, IDX_CFG);
  assign wsel_ctrl = ap_wr & clk_gate & sbc_hit(ap_addr, IDX_CTRL);
  assign wsel_own  = ap_wr & clk_gate & sbc_hit(ap_addr, IDX_OWN);
  assign wsel_buf  = ap_wr & clk_gate & sbc_hit(ap_addr, IDX_BUF);
  assign wsel_en   = ap_wr & sbc_hit(ap_addr, IDX_IRQ_EN);
  assign wsel_clr  = ap_wr & sbc_hit(ap_addr, IDX_IRQ_CLR);

  assign soft_rst  = wsel_ctrl & mode_sel & soft_reset_code_armed & (wdata[1:0] == SOFT_RESET_CODE_FIRE);
  assign init_regs = soft_rst | LOW_POWER_ENTRY_IN;
  assign do_cmd    = wdata[CTL_MST] & wdata[CTL_TRX] & wdata[CTL_PIN];

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      clk_gate <= 1'b0;
    end else if (wsel_gate) begin
      clk_gate <= wdata[0];
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      cfg      <= CFG_RST;
      own_addr <= OWN_RST;
    end else if (init_regs) begin
      cfg      <= CFG_RST;
      own_addr <= OWN_RST;
    end else begin
      if (wsel_cfg) cfg <= wdata;
      if (wsel_own) own_addr <= wdata;
    end
  end

  // ----------------------------------------------------------------------
  // Line synchronisers and bus condition detection
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      {scl_meta, scl_sync, scl_prev} <= 3'h7;
      {sda_meta, sda_sync, sda_prev} <= 3'h7;
    end else begin
      {scl_meta, scl_sync, scl_prev} <= {SCL_IN, scl_meta, scl_sync};
      {sda_meta, sda_sync, sda_prev} <= {SDA_IN, sda_meta, sda_sync};
    end
  end

  assign scl_rise  = scl_sync & ~scl_prev;
  assign scl_fall  = ~scl_sync & scl_prev;
  assign start_det = scl_sync & scl_prev & sda_prev & ~sda_sync;
  assign stop_det  = scl_sync & scl_prev & ~sda_prev & sda_sync;

  assign m_cycles   = sbc_high_cycles(cfg[2:0]);
  // Load is one short, since the counter also spends a cycle at zero
  assign n_cycles   = m_cycles + LOW_EXTRA - 9'h001;
  assign data_bits  = addr_phase ? ADDR_BITS : sbc_data_bits(cfg[7:CFG_BC_LSB]);
  assign total_bits = data_bits + {3'h0, (addr_phase | cfg[CFG_ACK])};
  assign data_slot  = bit_cnt < data_bits;

  // ----------------------------------------------------------------------
  // Control, status and bit engine
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      state        <= ST_IDLE;
      cnt          <= 9'h000;
      bit_cnt      <= 4'h0;
      addr_phase   <= 1'b0;
      {master_select, transmit_select, bb, al, aas, ad0, lrb} <= 7'h00;
      pin          <= 1'b1;
      mode_sel     <= 1'b0;
      soft_reset_code_armed  <= 1'b0;
      shift_buffer <= BUF_RST;
      {ev_done, ev_al, ev_match} <= 3'h0;
    end else begin
      {ev_done, ev_al, ev_match} <= 3'h0;
      if (clk_gate) begin
        if (start_det) bb <= 1'b1;
        else if (stop_det) bb <= 1'b0;
        if (wsel_ctrl) begin
          mode_sel <= wdata[CTL_MODE];
          if (mode_sel) begin
            soft_reset_code_armed <= (wdata[1:0] == SOFT_RESET_CODE_ARM);
            master_select <= wdata[CTL_MST];
            transmit_select <= wdata[CTL_TRX];
            if (wdata[CTL_PIN]) pin <= 1'b1;
            if (do_cmd && wdata[CTL_BB] && !bb && state == ST_IDLE) begin
              state <= ST_START;
              cnt   <= m_cycles;
            end else if (do_cmd && !wdata[CTL_BB] && state == ST_HOLD) begin
              state <= ST_STOP_LOW;
              cnt   <= n_cycles;
            end else if (wdata[CTL_PIN] && state == ST_HOLD) begin
              state <= ST_LOW;
              cnt   <= wdata[CTL_MST] ? n_cycles : m_cycles;
            end
          end
          if (!wdata[CTL_MODE]) begin
            {master_select, transmit_select, al, aas, ad0, lrb} <= 6'h00;
            pin   <= 1'b1;
            state <= ST_IDLE;
          end
        end
        // Loading the buffer while held also resumes the transfer
        if (wsel_buf) begin
          shift_buffer <= wdata;
          if (state == ST_HOLD) begin
            pin   <= 1'b1;
            state <= ST_LOW;
            cnt   <= master_select ? n_cycles : m_cycles;
          end
        end
        unique case (state)
          ST_IDLE: begin
            if (start_det && mode_sel && !master_select) begin
              state      <= ST_SLAVE;
              bit_cnt    <= 4'h0;
              addr_phase <= 1'b1;
              {transmit_select, aas, ad0} <= 3'h0;
            end
          end
          ST_START: begin
            if (cnt == 9'h000) begin
              state      <= ST_LOW;
              cnt        <= n_cycles;
              bit_cnt    <= 4'h0;
              addr_phase <= 1'b0;
            end else begin
              cnt <= cnt - 9'h001;
            end
          end
          ST_LOW: begin
            if (cnt == 9'h000) begin
              state <= master_select ? ST_HIGH : ST_SLAVE;
              cnt   <= m_cycles - HIGH_LAG;
            end else begin
              cnt <= cnt - 9'h001;
            end
          end
          ST_HIGH: begin
            if (scl_rise) begin
              if (data_slot) begin
                shift_buffer <= {shift_buffer[6:0], sda_sync};
                if (transmit_select && shift_buffer[7] && !sda_sync) begin
                  al    <= 1'b1;
                  ev_al <= 1'b1;
                  master_select   <= 1'b0;
                  state <= ST_IDLE;
                end
              end else begin
                lrb <= sda_sync;
              end
            end
            // Count starts only once SCL is really high, so stretching is honoured
            if (scl_sync) begin
              if (cnt == 9'h000) begin
                if (bit_cnt == total_bits - 4'h1) begin
                  state   <= ST_HOLD;
                  pin     <= 1'b0;
                  ev_done <= 1'b1;
                  bit_cnt <= 4'h0;
                end else begin
                  state   <= ST_LOW;
                  cnt     <= n_cycles;
                  bit_cnt <= bit_cnt + 4'h1;
                end
              end else begin
                cnt <= cnt - 9'h001;
              end
            end
          end
          ST_HOLD: begin
            if (stop_det && !master_select) state <= ST_IDLE;
          end
          ST_STOP_LOW: begin
            if (cnt == 9'h000) begin
              state <= ST_STOP_HIGH;
              cnt   <= m_cycles;
            end else begin
              cnt <= cnt - 9'h001;
            end
          end
          ST_STOP_HIGH: begin
            if (scl_sync) begin
              if (cnt == 9'h000) begin
                state <= ST_IDLE;
                master_select   <= 1'b0;
                transmit_select   <= 1'b0;
              end else begin
                cnt <= cnt - 9'h001;
              end
            end
          end
          ST_SLAVE: begin
            if (scl_rise) begin
              if (data_slot) shift_buffer <= {shift_buffer[6:0], sda_sync};
              else lrb <= sda_sync;
              if (addr_phase && bit_cnt == ADDR_LAST && !cfg[CFG_NOMATCH]) begin
                if (shift_buffer[6:0] == own_addr[7:1] ||
                    (shift_buffer[6:0] == GCALL_ADDR && !sda_sync)) begin
                  aas      <= 1'b1;
                  ad0      <= (shift_buffer[6:0] == GCALL_ADDR);
                  transmit_select      <= sda_sync;
                  ev_match <= 1'b1;
                end
              end
              bit_cnt <= bit_cnt + 4'h1;
            end
            if (scl_fall && bit_cnt == total_bits) begin
              addr_phase <= 1'b0;
              bit_cnt    <= 4'h0;
              if (addr_phase && !aas) begin
                state <= ST_IDLE;
              end else begin
                state   <= ST_HOLD;
                pin     <= 1'b0;
                ev_done <= 1'b1;
              end
            end
            if (stop_det) state <= ST_IDLE;
          end
        endcase
      end
      if (init_regs) begin
        state       <= ST_IDLE;
        {master_select, transmit_select, al, aas, ad0, lrb} <= 6'h00;
        pin         <= 1'b1;
        soft_reset_code_armed <= 1'b0;
        addr_phase  <= 1'b0;
        if (LOW_POWER_ENTRY_IN) shift_buffer <= BUF_RST;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Line drivers; SDA frozen while SCL is high during every bit, data and acknowledge, and in hold, so no false start or stop
  // ----------------------------------------------------------------------
  always_comb begin
    next_scl_oe = 1'b0;
    next_sda_oe = 1'b0;
    unique case (state)
      ST_START, ST_STOP_HIGH: next_sda_oe = 1'b1;
      ST_STOP_LOW: begin
        next_scl_oe = 1'b1;
        next_sda_oe = 1'b1;
      end
      ST_LOW, ST_HIGH, ST_SLAVE, ST_HOLD: begin
        next_scl_oe = (state == ST_LOW) || (state == ST_HOLD);
        next_sda_oe = data_slot ? (transmit_select & ~shift_buffer[7]) : (~transmit_select & (master_select | aas));
      end
      ST_IDLE: next_sda_oe = 1'b0;
    endcase
  end

  assign sda_freeze = (state == ST_HOLD) ||
                      ((state == ST_HIGH || state == ST_SLAVE) && scl_sync);

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      SCL_OE_OUT <= 1'b0;
      SDA_OE_OUT <= 1'b0;
    end else if (!mode_sel) begin
      SCL_OE_OUT <= 1'b0;
      SDA_OE_OUT <= 1'b0;
    end else begin
      SCL_OE_OUT <= next_scl_oe;
      if (!sda_freeze) SDA_OE_OUT <= next_sda_oe;
    end
  end

  // ----------------------------------------------------------------------
  // Interrupt status, enable and clear; a new event beats its own clear
  // ----------------------------------------------------------------------
  assign irq_ev  = {stop_det & clk_gate & mode_sel, ev_match, ev_al, ev_done};
  assign irq_clr = wsel_clr ? wdata[3:0] : 4'h0;

  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      irq_stat <= IRQ_RST;
      irq_en   <= IRQ_RST;
      IRQ_OUT  <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
      if (wsel_en) irq_en <= wdata[3:0];
      IRQ_OUT  <= |(irq_stat & irq_en);
    end
  end
endmodule

// ### sim/sbc_monitor.sv
/*
  Concurrent checks on the ports of the serial bus control block.
  Assumes it is bound to sbc_top and clocked by the gear clock.
*/
module sbc_monitor (
  input wire logic        SYS_CLK_IN,
  input wire logic        ARST_N_IN,
  input wire logic [31:0] HRDATA_OUT,
  input wire logic        HREADYOUT_OUT,
  input wire logic        HRESP_OUT,
  input wire logic        SCL_IN,
  input wire logic        SCL_OUT,
  input wire logic        SCL_OE_OUT,
  input wire logic        SDA_OUT,
  input wire logic        SDA_OE_OUT,
  input wire logic        BUS_MODE_OUT,
  input wire logic        IRQ_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------------
  // Phase length counters, saturating so long idle spans cannot wrap
  // ----------------------------------------------------------------------
  logic [8:0] low_cnt;
  logic [8:0] high_cnt;
  always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      low_cnt  <= 9'h000;
      high_cnt <= 9'h000;
    end else begin
      low_cnt  <= !SCL_OE_OUT ? 9'h000 : low_cnt + {8'h00, low_cnt != 9'h1ff};
      high_cnt <= SCL_OE_OUT ? 9'h000 : high_cnt + {8'h00, high_cnt != 9'h1ff};
    end
  end

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!ARST_N_IN);

  sequence s_start;
    $rose(SDA_OE_OUT) && !SCL_OE_OUT && SCL_IN;
  endsequence
  sequence s_scl_free;
    !SCL_OE_OUT [*8];
  endsequence

  a_bus_okay: assert property (HREADYOUT_OUT && !HRESP_OUT)
    else $error("bus answer not ready or not okay");
  a_rdata_upper: assert property (HRDATA_OUT[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_open_drain: assert property (!SCL_OUT && !SDA_OUT)
    else $error("line driven high");
  a_reset_quiet: assert property (disable iff (1'b0)
    !ARST_N_IN |-> !SCL_OE_OUT && !SDA_OE_OUT && !IRQ_OUT && !BUS_MODE_OUT)
    else $error("outputs active in reset");
  a_port_release: assert property (!BUS_MODE_OUT && !$past(BUS_MODE_OUT)
    |-> !SCL_OE_OUT && !SDA_OE_OUT)
    else $error("lines pulled in port mode");
  a_start_hold: assert property (s_start |-> s_scl_free)
    else $error("clock pulled too soon after start");
  a_scl_low_len: assert property ($fell(SCL_OE_OUT) |-> low_cnt >= 9'd12)
    else $error("clock low phase too short");
  a_scl_high_len: assert property ($rose(SCL_OE_OUT) && BUS_MODE_OUT
    |-> high_cnt >= 9'd9)
    else $error("clock high phase too short");
endmodule

bind sbc_top sbc_monitor i_mon (
  .SYS_CLK_IN    (SYS_CLK_IN),
  .ARST_N_IN     (ARST_N_IN),
  .HRDATA_OUT    (HRDATA_OUT),
  .HREADYOUT_OUT (HREADYOUT_OUT),
  .HRESP_OUT     (HRESP_OUT),
  .SCL_IN        (SCL_IN),
  .SCL_OUT       (SCL_OUT),
  .SCL_OE_OUT    (SCL_OE_OUT),
  .SDA_OUT       (SDA_OUT),
  .SDA_OE_OUT    (SDA_OE_OUT),
  .BUS_MODE_OUT  (BUS_MODE_OUT),
  .IRQ_OUT       (IRQ_OUT)
);

// ### sim/sbc_peer.sv
/*
  Receiving device on the two-wire bus: acknowledges and stretches the clock.
  Assumes the bench resolves both wires with pull-ups.
*/
module sbc_peer (
  input  wire logic       clk_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       ack_en_in,
  input  wire logic [7:0] stretch_in,
  output logic            scl_oe_out,
  output logic            sda_oe_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       scl_q   = 1'b1;
  logic       sda_q   = 1'b1;
  logic       ack_drv = 1'b0;
  logic [3:0] bits    = 4'h0;
  logic [7:0] hold    = 8'h00;
  assign sda_oe_out = ack_drv;
  assign scl_oe_out = (hold != 8'h00);
  // Released lines fall back to the pull-up, never to a stale level
  always @(posedge clk_in) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    if (sda_q && !sda_in && scl_in) begin
      bits <= 4'h0;
    end else if (!scl_q && scl_in) begin
      bits <= (bits == 4'h9) ? 4'h1 : bits + 4'h1;
    end
    if (scl_q && !scl_in) begin
      ack_drv <= ack_en_in && (bits == 4'h8);
      hold    <= stretch_in;
    end else if (hold != 8'h00) begin
      hold <= hold - 8'h01;
    end
  end
endmodule

// ### sim/testbench.sv
/*
  Self-checking bench for the serial bus control block.
  Assumes the peer model on the wires and an AHB-Lite master in tasks.
*/
module testbench
  import sbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk     = 1'b0;
  logic        arst_n  = 1'b1;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic        lp      = 1'b0;
  logic        ack_en  = 1'b1;
  logic [7:0]  stretch = 8'h00;
  logic [31:0] hrdata;
  logic        hready, hresp, scl_oe, sda_oe, bus_mode, irq, p_scl_oe, p_sda_oe;
  wire         scl = !(scl_oe | p_scl_oe);
  wire         sda = !(sda_oe | p_sda_oe);
  int          err_count = 0;
  int          n_tests = 0;
  int          m_tab[8] = '{9, 11, 15, 23, 39, 71, 135, 263};
  int          n_tab[8] = '{12, 14, 18, 26, 42, 74, 138, 266};
  always #5 clk = ~clk;

  sbc_top i_dut (
    .SYS_CLK_IN         (clk),
    .ARST_N_IN          (arst_n),
    .HSEL_IN            (hsel),
    .HADDR_IN           (haddr),
    .HTRANS_IN          (htrans),
    .HWRITE_IN          (hwrite),
    .HSIZE_IN           (3'h2),
    .HWDATA_IN          (hwdata),
    .HREADY_IN          (hready),
    .HRDATA_OUT         (hrdata),
    .HREADYOUT_OUT      (hready),
    .HRESP_OUT          (hresp),
    .SCL_IN             (scl),
    .SCL_OUT            (),
    .SCL_OE_OUT         (scl_oe),
    .SDA_IN             (sda),
    .SDA_OUT            (),
    .SDA_OE_OUT         (sda_oe),
    .LOW_POWER_ENTRY_IN (lp),
    .BUS_MODE_OUT       (bus_mode),
    .IRQ_OUT            (irq)
  );
  sbc_peer i_peer (
    .clk_in     (clk),
    .scl_in     (scl),
    .sda_in     (sda),
    .ack_en_in  (ack_en),
    .stretch_in (stretch),
    .scl_oe_out (p_scl_oe),
    .sda_oe_out (p_sda_oe)
  );

  // ----------------------------------------------------------------------
  // Bus cycles, comparisons and expectations
  // ----------------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] unused;
    bus(1'b1, idx, d, unused);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp,
                        input logic [7:0] mask);
    logic [7:0] v;
    bus(1'b0, idx, 8'h00, v);
    chk(what, {24'h0, exp & mask}, {24'h0, v & mask});
  endtask
  // Pin is picked by number and read after the wait, so the settled level is seen
  task automatic pin_chk(input string what, input logic exp, input int pin_id);
    logic got;
    repeat (2) @(negedge clk);
    got = (pin_id == 0) ? bus_mode : (pin_id == 1) ? sda_oe : irq;
    chk(what, {31'h0, exp}, {31'h0, got});
  endtask
  task automatic phase(input logic lvl, output int c);
    c = 0;
    while (scl_oe !== lvl) @(negedge clk);
    while (scl_oe === lvl) begin
      c++;
      @(negedge clk);
    end
  endtask
  function automatic int low_of(input logic [2:0] s);
    return n_tab[s];
  endfunction

  initial begin
    #600000;
    err_count++;
    summarize();
  end

  initial begin
    logic [7:0] v;
    logic [2:0] sel;
    int         h;
    int         l;
    // Falling edge at time zero resets the design before the first clock
    arst_n <= 1'b0;
    void'($urandom(51));
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    rd_chk("status at reset", IDX_CTRL, 8'h10, 8'hff);
    v = 8'($urandom) | 8'h01;
    wr(IDX_CFG, v);
    rd_chk("cfg gated", IDX_CFG, CFG_RST, 8'hff);
    wr(IDX_GATE, 8'h01);
    wr(IDX_CTRL, 8'hf0);
    rd_chk("ctrl in port mode", IDX_CTRL, 8'h10, 8'hff);
    pin_chk("port mode", 1'b0, 0);
    chk("lines high", 32'h1, {31'h0, scl & sda});
    wr(IDX_CTRL, 8'h08);
    pin_chk("bus mode", 1'b1, 0);
    rd_chk("unmapped", 8'h3f, 8'h00, 8'hff);
    wr(IDX_CFG, v);
    wr(IDX_CTRL, 8'h09);
    rd_chk("cfg after lone fire", IDX_CFG, v, 8'hff);
    wr(IDX_CTRL, 8'h0a);
    wr(IDX_CTRL, 8'h09);
    rd_chk("cfg soft reset", IDX_CFG, CFG_RST, 8'hff);
    rd_chk("status soft reset", IDX_CTRL, 8'h10, 8'hff);
    pin_chk("mode kept", 1'b1, 0);
    wr(IDX_CFG, v);
    wr(IDX_OWN, v);
    wr(IDX_BUF, v);
    @(posedge clk);
    lp <= 1'b1;
    @(posedge clk);
    lp <= 1'b0;
    rd_chk("cfg power entry", IDX_CFG, CFG_RST, 8'hff);
    rd_chk("own power entry", IDX_OWN, OWN_RST, 8'hff);
    rd_chk("buf power entry", IDX_BUF, BUF_RST, 8'hff);
    // Every code is legal at this gear clock, so any draw is fair
    sel = 3'($urandom);
    wr(IDX_CFG, {3'h0, 1'b1, 1'b0, sel});
    wr(IDX_IRQ_EN, 8'h01);
    wr(IDX_CTRL, 8'he8);
    pin_chk("no start", 1'b0, 1);
    rd_chk("status no release", IDX_CTRL, 8'hd0, 8'hff);
    wr(IDX_BUF, 8'ha0);
    wr(IDX_CTRL, 8'hf8);
    phase(1'b1, l);
    phase(1'b0, h);
    phase(1'b1, l);
    chk("scl low", low_of(sel), l);
    chk("scl high", m_tab[sel], h);
    while (irq !== 1'b1) @(posedge clk);
    rd_chk("status acked", IDX_CTRL, 8'he0, 8'hff);
    wr(IDX_IRQ_EN, 8'h00);
    pin_chk("irq masked", 1'b0, 2);
    wr(IDX_IRQ_CLR, 8'h0f);
    wr(IDX_IRQ_EN, 8'h09);
    pin_chk("irq cleared", 1'b0, 2);
    @(posedge clk);
    stretch <= 8'($urandom_range(60, 20));
    ack_en  <= 1'b0;
    wr(IDX_BUF, 8'($urandom));
    while (irq !== 1'b1) @(posedge clk);
    rd_chk("status nacked", IDX_CTRL, 8'he1, 8'hff);
    wr(IDX_IRQ_CLR, 8'h01);
    wr(IDX_CTRL, 8'hd8);
    while (irq !== 1'b1) @(posedge clk);
    rd_chk("stop seen", IDX_IRQ_STAT, 8'h08, 8'h0f);
    rd_chk("bus free", IDX_CTRL, 8'h00, 8'h20);
    summarize();
  end
endmodule
